// ---- src/otps_param_store.sv ----
// Fuse parameter store with working copy, address forming and fallback logic.
module otps_param_store
    import otps_pkg::*;
#(
    parameter otps_image_t FUSE_INIT = OTPS_DELIVERY_IMAGE,
    parameter int DEB_SHORT_CYC = OTPS_DEB_SHORT_US * OTPS_CLK_MHZ,
    parameter int DEB_LONG_CYC = OTPS_DEB_LONG_US * OTPS_CLK_MHZ
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic power_cycle,
    input wire logic wake_up,
    input wire logic prog_req,
    input wire logic [3:0] prog_idx,
    input wire logic [7:0] prog_data,
    output logic prog_busy,
    output logic prog_done,
    output logic prog_refused,
    input wire logic read_req,
    input wire logic [3:0] read_idx,
    output logic [7:0] read_data,
    output logic read_valid,
    input wire logic set_req,
    input wire otps_settings_t set_data,
    output otps_settings_t work,
    input wire logic [2:0] strap_address_pins,
    output logic [7:0] node_address,
    input wire logic comm_lost,
    input wire logic err_overflow,
    input wire logic goto_fallback_cmd,
    output logic fallback_go,
    output logic fallback_hold,
    output logic [15:0] fallback_pos,
    input wire logic motor_stopped,
    output logic [3:0] coil_current_code,
    output logic regulator_off,
    output logic bridge_low_gnd,
    output logic [4:0] step_divider,
    output logic motion_detect_en,
    input wire logic supply_above_recover,
    output logic supply_recovered
);

    // --------------------
    // Derived cycle counts
    // --------------------
    localparam int ZAP_CYC = OTPS_ZAP_TIME_US * OTPS_CLK_MHZ;
    localparam int DIP_CYC = OTPS_DIP_TIME_US * OTPS_CLK_MHZ;
    localparam logic [11:0] ZAP_LAST = 12'(ZAP_CYC - 1);
    localparam logic [11:0] DIP_LAST = 12'(DIP_CYC - 1);
    localparam logic [17:0] DEB_SHORT_LAST = 18'(DEB_SHORT_CYC - 1);
    localparam logic [17:0] DEB_LONG_LAST = 18'(DEB_LONG_CYC - 1);

    // --------------------
    // Helper functions
    // --------------------

    // Bits that the factory lock keeps from being zapped.
    function automatic logic [7:0] prot_mask(input logic [3:0] idx, input logic flock);
        logic [7:0] m;
        m = 8'h00;
        if (flock) begin
            if (idx == OTPS_B_CAL_A) begin
                m = OTPS_PROT_CAL_A;
            end else if (idx == OTPS_B_CAL_B) begin
                m = OTPS_PROT_CAL_B;
            end else if (idx == OTPS_B_ALT_HI) begin
                m = OTPS_PROT_ALT_HI;
            end
        end
        return m;
    endfunction

    // Readback remaps the obsolete fallback bytes when the alternate bank is chosen.
    function automatic logic [3:0] read_map(input logic [3:0] idx, input logic alt);
        logic [3:0] r;
        r = idx;
        if (alt && idx == OTPS_B_FB_HI) begin
            r = OTPS_B_ALT_HI;
        end else if (alt && idx == OTPS_B_FB_LO) begin
            r = OTPS_B_ALT_LO;
        end
        return r;
    endfunction

    // Builds the working copy from a fuse image.
    function automatic otps_settings_t fuse_to_work(input otps_image_t f);
        otps_settings_t w;
        logic alt;
        logic [7:0] hi;
        logic [7:0] lo;
        alt = f[OTPS_B_CAL_B][OTPS_ALT_SEL_POS];
        hi = alt ? f[OTPS_B_ALT_HI] : f[OTPS_B_FB_HI];
        lo = alt ? f[OTPS_B_ALT_LO] : f[OTPS_B_FB_LO];
        w.run_code = f[OTPS_B_COIL][OTPS_RUN_LSB +: 4];
        w.hold_code = f[OTPS_B_COIL][OTPS_HOLD_LSB +: 4];
        w.vmax = f[OTPS_B_SPEED][OTPS_VMAX_LSB +: 4];
        w.vmin = f[OTPS_B_SPEED][OTPS_VMIN_LSB +: 4];
        w.acc = f[OTPS_B_FB_HI][OTPS_ACC_LSB +: 4];
        w.dir = f[OTPS_B_FB_HI][OTPS_DIR_POS];
        w.motion_lvl = f[OTPS_B_THR_ADDR][OTPS_LVL_LSB +: 4];
        w.step_res = f[OTPS_B_SUP_LOCK][OTPS_STEP_LSB +: 2];
        w.warn_code = f[OTPS_B_SUP_LOCK][OTPS_WARN_LSB +: 3];
        w.deb_long = f[OTPS_B_SUP_LOCK][OTPS_DEB_POS];
        w.merge = f[OTPS_B_CAL_B][OTPS_MERGE_POS];
        w.fb_target = {hi[OTPS_FBH_LSB +: 3], lo[OTPS_FBL_LSB +: 6], 2'b00};
        w.comm_loss = lo[OTPS_LOSS_POS];
        w.low_pwr = lo[OTPS_LOWPWR_POS];
        return w;
    endfunction

    // --------------------
    // State
    // --------------------
    typedef struct packed {
        otps_image_t fuse;
        otps_settings_t work;
        logic [3:0] node_bits;
        logic load_pend;
        otps_prog_t pg;
        logic [11:0] pg_cnt;
        logic [3:0] pg_idx;
        logic [7:0] pg_bits;
        logic done;
        logic refused;
        logic [7:0] rd_data;
        logic rd_valid;
        logic [2:0] hw1;
        logic [2:0] hw2;
        logic [2:0] hw3;
        logic [2:0] hw;
        logic [7:0] nad;
        logic fb_go;
        logic fb_hold;
        logic [15:0] fb_pos;
        otps_cur_t cur;
        logic [11:0] cur_cnt;
        logic [3:0] coil;
        logic reg_off;
        logic sup1;
        logic sup2;
        logic sup3;
        logic sup_lvl;
        logic [17:0] deb_cnt;
        logic recovered;
    } otps_state_t;

    otps_state_t s_reg;
    otps_state_t s_next;

    logic user_locked;
    logic fact_locked;
    logic [7:0] want;
    logic [7:0] cur_byte;
    logic fb_disabled;
    logic [17:0] deb_last;

    // --------------------
    // Next-state logic
    // --------------------

    // All next-state logic in one pass.
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.refused = 1'b0;
        s_next.rd_valid = 1'b0;
        s_next.fb_go = 1'b0;
        s_next.fb_hold = 1'b0;
        user_locked = s_reg.fuse[OTPS_B_SUP_LOCK][OTPS_ULOCK_POS];
        fact_locked = s_reg.fuse[OTPS_B_SUP_LOCK][OTPS_FLOCK_POS];
        cur_byte = (prog_idx <= OTPS_LAST_IDX) ? s_reg.fuse[prog_idx] : 8'h00;
        // Bits already at one are simply skipped; zapping them is meaningless.
        want = prog_data & ~cur_byte;
        fb_disabled = (s_reg.work.fb_target[10:2] == OTPS_FB_OFF_CODE);
        deb_last = s_reg.work.deb_long ? DEB_LONG_LAST : DEB_SHORT_LAST;

        // Fuse programming sequencer: one byte per command.
        case (s_reg.pg)
            OTPS_PG_IDLE: begin
                if (prog_req) begin
                    if (prog_idx > OTPS_LAST_IDX || user_locked) begin
                        s_next.refused = 1'b1;
                    end else if ((want & prot_mask(prog_idx, fact_locked)) != 8'h00) begin
                        s_next.refused = 1'b1;
                    end else begin
                        s_next.pg = OTPS_PG_ZAP;
                        s_next.pg_idx = prog_idx;
                        s_next.pg_bits = want;
                        s_next.pg_cnt = 12'h000;
                    end
                end
            end
            OTPS_PG_ZAP: begin
                if (s_reg.pg_cnt == ZAP_LAST) begin
                    // Zapping only ever sets bits; only reset, which reloads the delivery image, returns a bit to zero.
                    s_next.fuse[s_reg.pg_idx] = s_reg.fuse[s_reg.pg_idx] | s_reg.pg_bits;
                    s_next.pg = OTPS_PG_DONE;
                end else begin
                    s_next.pg_cnt = s_reg.pg_cnt + 12'h001;
                end
            end
            OTPS_PG_DONE: begin
                s_next.done = 1'b1;
                s_next.pg = OTPS_PG_IDLE;
            end
            default: begin
                s_next.pg = OTPS_PG_IDLE;
            end
        endcase

        // Readback shows fuse contents, which may differ from the working copy.
        if (read_req) begin
            s_next.rd_valid = 1'b1;
            s_next.rd_data = 8'h00;
            if (read_idx <= OTPS_LAST_IDX) begin
                s_next.rd_data = s_reg.fuse[read_map(read_idx,
                    s_reg.fuse[OTPS_B_CAL_B][OTPS_ALT_SEL_POS])];
            end
        end

        // Preload happens only after reset release, power-up or wake-up, so fresh zaps stay dormant.
        if (power_cycle || wake_up) begin
            s_next.load_pend = 1'b1;
        end
        if (s_reg.load_pend && s_reg.pg == OTPS_PG_IDLE) begin
            s_next.work = fuse_to_work(s_reg.fuse);
            s_next.node_bits = s_reg.fuse[OTPS_B_THR_ADDR][OTPS_NODE_LSB +: 4];
            s_next.load_pend = power_cycle || wake_up;
        end else if (set_req) begin
            // The node address bits live apart and are never written here.
            s_next.work = set_data;
        end

        // Strap pins: three stages, a change counts once stages two and three agree.
        s_next.hw1 = strap_address_pins;
        s_next.hw2 = s_reg.hw1;
        s_next.hw3 = s_reg.hw2;
        if (s_reg.hw2 == s_reg.hw3) begin
            s_next.hw = s_reg.hw3;
        end
        if (s_reg.work.merge) begin
            s_next.nad = {1'b0, s_reg.hw, s_reg.node_bits};
        end else begin
            s_next.nad = {1'b0, s_reg.node_bits, s_reg.hw};
        end

        // Fallback move: explicit command always moves, automatic trigger may be off.
        if (goto_fallback_cmd) begin
            s_next.fb_go = 1'b1;
        end else if (comm_lost || err_overflow) begin
            s_next.fb_go = !fb_disabled;
            s_next.fb_hold = fb_disabled;
        end
        s_next.fb_pos = {s_reg.work.fb_target, 5'b0_0000};

        // Coil current sequencer.
        case (s_reg.cur)
            OTPS_CUR_RUN: begin
                s_next.coil = s_reg.work.run_code;
                s_next.reg_off = 1'b0;
                if (motor_stopped) begin
                    s_next.cur_cnt = 12'h000;
                    if (s_reg.work.hold_code == OTPS_HOLD_ZERO) begin
                        s_next.cur = OTPS_CUR_DIP;
                        s_next.coil = OTPS_CODE_LOWEST;
                    end else begin
                        s_next.cur = OTPS_CUR_HOLD;
                        s_next.coil = s_reg.work.hold_code;
                    end
                end
            end
            OTPS_CUR_HOLD: begin
                s_next.coil = s_reg.work.hold_code;
                if (!motor_stopped) begin
                    s_next.cur = OTPS_CUR_RUN;
                    s_next.coil = s_reg.work.run_code;
                end
            end
            OTPS_CUR_DIP: begin
                if (!motor_stopped) begin
                    s_next.cur = OTPS_CUR_RUN;
                    s_next.coil = s_reg.work.run_code;
                end else if (s_reg.cur_cnt == DIP_LAST) begin
                    s_next.cur = OTPS_CUR_OFF;
                    s_next.reg_off = 1'b1;
                end else begin
                    s_next.cur_cnt = s_reg.cur_cnt + 12'h001;
                end
            end
            OTPS_CUR_OFF: begin
                if (!motor_stopped) begin
                    s_next.cur = OTPS_CUR_RUN;
                    s_next.coil = s_reg.work.run_code;
                    s_next.reg_off = 1'b0;
                end
            end
            default: begin
                s_next.cur = OTPS_CUR_RUN;
            end
        endcase

        // Supply recovery: three stages, then debounce before declaring recovery.
        s_next.sup1 = supply_above_recover;
        s_next.sup2 = s_reg.sup1;
        s_next.sup3 = s_reg.sup2;
        if (s_reg.sup2 == s_reg.sup3) begin
            s_next.sup_lvl = s_reg.sup3;
        end
        if (!s_reg.sup_lvl) begin
            s_next.recovered = 1'b0;
            s_next.deb_cnt = 18'h0_0000;
        end else if (!s_reg.recovered) begin
            if (s_reg.deb_cnt >= deb_last) begin
                s_next.recovered = 1'b1;
            end else begin
                s_next.deb_cnt = s_reg.deb_cnt + 18'h0_0001;
            end
        end
    end

    // --------------------
    // State register
    // --------------------

    // The fuse image resets to its delivery contents; a preload follows release.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.fuse <= FUSE_INIT;
            s_reg.load_pend <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // --------------------
    // Outputs
    // --------------------

    // Outputs come from registered fields.
    assign prog_busy = (s_reg.pg != OTPS_PG_IDLE);
    assign prog_done = s_reg.done;
    assign prog_refused = s_reg.refused;
    assign read_data = s_reg.rd_data;
    assign read_valid = s_reg.rd_valid;
    assign work = s_reg.work;
    assign node_address = s_reg.nad;
    assign fallback_go = s_reg.fb_go;
    assign fallback_hold = s_reg.fb_hold;
    assign fallback_pos = s_reg.fb_pos;
    assign coil_current_code = s_reg.coil;
    assign regulator_off = s_reg.reg_off;
    assign bridge_low_gnd = s_reg.reg_off;
    assign step_divider = 5'b0_0010 << s_reg.work.step_res;
    assign motion_detect_en = (s_reg.work.motion_lvl != 4'h0);
    assign supply_recovered = s_reg.recovered;

endmodule

// ---- src/otps_pkg.sv ----
// Shared constants and types for the fuse-backed parameter store.
package otps_pkg;

    // --------------------
    // Store geometry and byte map
    // --------------------
    localparam int OTPS_BYTES = 10;
    localparam logic [3:0] OTPS_LAST_IDX = 4'h9;
    localparam logic [3:0] OTPS_B_CAL_A = 4'h0;
    localparam logic [3:0] OTPS_B_CAL_B = 4'h1;
    localparam logic [3:0] OTPS_B_THR_ADDR = 4'h2;
    localparam logic [3:0] OTPS_B_COIL = 4'h3;
    localparam logic [3:0] OTPS_B_SPEED = 4'h4;
    localparam logic [3:0] OTPS_B_FB_HI = 4'h5;
    localparam logic [3:0] OTPS_B_FB_LO = 4'h6;
    localparam logic [3:0] OTPS_B_SUP_LOCK = 4'h7;
    localparam logic [3:0] OTPS_B_ALT_HI = 4'h8;
    localparam logic [3:0] OTPS_B_ALT_LO = 4'h9;

    // --------------------
    // Field positions (lowest bit of each field)
    // --------------------
    localparam int OTPS_ALT_SEL_POS = 7;
    localparam int OTPS_MERGE_POS = 6;
    localparam int OTPS_NODE_LSB = 0;
    localparam int OTPS_LVL_LSB = 4;
    localparam int OTPS_HOLD_LSB = 0;
    localparam int OTPS_RUN_LSB = 4;
    localparam int OTPS_VMIN_LSB = 0;
    localparam int OTPS_VMAX_LSB = 4;
    localparam int OTPS_ACC_LSB = 0;
    localparam int OTPS_DIR_POS = 4;
    localparam int OTPS_FBH_LSB = 5;
    localparam int OTPS_FBL_LSB = 2;
    localparam int OTPS_LOSS_POS = 1;
    localparam int OTPS_LOWPWR_POS = 0;
    localparam int OTPS_ULOCK_POS = 0;
    localparam int OTPS_FLOCK_POS = 1;
    localparam int OTPS_STEP_LSB = 2;
    localparam int OTPS_WARN_LSB = 4;
    localparam int OTPS_DEB_POS = 7;

    // --------------------
    // Protection masks and special codes
    // --------------------
    localparam logic [7:0] OTPS_PROT_CAL_A = 8'h7F;
    localparam logic [7:0] OTPS_PROT_CAL_B = 8'h3F;
    localparam logic [7:0] OTPS_PROT_ALT_HI = 8'h1F;
    localparam logic [8:0] OTPS_FB_OFF_CODE = 9'h100;
    localparam logic [3:0] OTPS_HOLD_ZERO = 4'hF;
    localparam logic [3:0] OTPS_CODE_LOWEST = 4'h0;

    // --------------------
    // Timing
    // --------------------
    localparam int OTPS_CLK_MHZ = 100;
    localparam int OTPS_ZAP_TIME_US = 10;
    localparam int OTPS_DIP_TIME_US = 20;
    localparam int OTPS_DEB_SHORT_US = 256;
    localparam int OTPS_DEB_LONG_US = 2000;

    // --------------------
    // Types
    // --------------------
    typedef logic [OTPS_BYTES-1:0][7:0] otps_image_t;

    // Fuse image as delivered: only the factory lock bit is zapped.
    localparam otps_image_t OTPS_DELIVERY_IMAGE = 80'h0000_0200_0000_0000_0000;

    typedef struct packed {
        logic [3:0] run_code;
        logic [3:0] hold_code;
        logic [3:0] vmax;
        logic [3:0] vmin;
        logic [3:0] acc;
        logic [3:0] motion_lvl;
        logic [1:0] step_res;
        logic dir;
        logic [10:0] fb_target;
        logic comm_loss;
        logic low_pwr;
        logic [2:0] warn_code;
        logic deb_long;
        logic merge;
    } otps_settings_t;

    typedef enum logic [1:0] {
        OTPS_PG_IDLE = 2'b00,
        OTPS_PG_ZAP = 2'b01,
        OTPS_PG_DONE = 2'b11
    } otps_prog_t;

    typedef enum logic [1:0] {
        OTPS_CUR_RUN = 2'b00,
        OTPS_CUR_DIP = 2'b01,
        OTPS_CUR_OFF = 2'b11,
        OTPS_CUR_HOLD = 2'b10
    } otps_cur_t;

endpackage

// ---- dv/otps_param_store_chk.sv ----
// Port-level assertions for the fuse parameter store.
module otps_param_store_chk
    import otps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic prog_req,
    input wire logic [3:0] prog_idx,
    input wire logic prog_busy,
    input wire logic prog_refused,
    input wire logic read_req,
    input wire logic [3:0] read_idx,
    input wire logic [7:0] read_data,
    input wire logic read_valid,
    input wire otps_settings_t work,
    input wire logic comm_lost,
    input wire logic err_overflow,
    input wire logic goto_fallback_cmd,
    input wire logic fallback_go,
    input wire logic fallback_hold,
    input wire logic [15:0] fallback_pos,
    input wire logic motor_stopped,
    input wire logic [3:0] coil_current_code,
    input wire logic regulator_off,
    input wire logic bridge_low_gnd,
    input wire logic [4:0] step_divider
);
    timeunit 1ns;
    timeprecision 100ps;
    // --------------------
    // Assertions, all in the system clock domain
    // --------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    bad_index_a: assert property (
        prog_req && !prog_busy && prog_idx > 4'h9 |=> prog_refused)
        else $error("Index above nine not refused.");
    read_answer_a: assert property (
        read_req |=> read_valid && ($past(read_idx) <= 4'h9 || read_data == 8'h00))
        else $error("Readback answer wrong.");
    goto_go_a: assert property (
        goto_fallback_cmd |=> fallback_go && fallback_pos[4:0] == 5'h00)
        else $error("Explicit fallback move not started.");
    auto_hold_a: assert property (
        (comm_lost || err_overflow) && !goto_fallback_cmd && work.fb_target[10:2] == 9'h100
        |=> fallback_hold && !fallback_go)
        else $error("Disabled fallback still moved.");
    auto_go_a: assert property (
        (comm_lost || err_overflow) && !goto_fallback_cmd && work.fb_target[10:2] != 9'h100
        |=> fallback_go)
        else $error("Automatic fallback move missing.");
    step_div_a: assert property (
        $onehot(step_divider) && step_divider[work.step_res + 3'd1])
        else $error("Step divider wrong.");
    off_zero_a: assert property (
        regulator_off |-> bridge_low_gnd && coil_current_code == 4'h0)
        else $error("Regulator off state incomplete.");
    hold_level_a: assert property (
        $rose(motor_stopped) && work.hold_code != 4'hF |=> coil_current_code == $past(work.hold_code))
        else $error("Hold current not applied on stop.");
endmodule
bind otps_param_store otps_param_store_chk i_chk (.clk_sys, .rst_n, .prog_req, .prog_idx,
    .prog_busy, .prog_refused, .read_req, .read_idx, .read_data, .read_valid, .work,
    .comm_lost, .err_overflow, .goto_fallback_cmd, .fallback_go, .fallback_hold, .fallback_pos,
    .motor_stopped, .coil_current_code, .regulator_off, .bridge_low_gnd, .step_divider);

// ---- dv/otps_master_model.sv ----
// Bus master model issuing fuse program and readback commands.
module otps_master_model
    import otps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic prog_busy,
    input wire logic prog_done,
    input wire logic prog_refused,
    input wire logic [7:0] read_data,
    input wire logic read_valid,
    output logic prog_req,
    output logic [3:0] prog_idx,
    output logic [7:0] prog_data,
    output logic read_req,
    output logic [3:0] read_idx
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle lines at time zero.
    initial begin
        {prog_req, prog_idx, prog_data, read_req, read_idx} = '0;
    end
    // Readback; the answer stands only in the cycle after the request.
    task automatic fetch(input logic [3:0] idx, output logic [7:0] val, output logic ok);
        read_req = 1'b1;
        read_idx = idx;
        @(posedge clk_sys);
        #1 read_req = 1'b0;
        read_idx = ~idx;
        ok = read_valid;
        val = read_data;
    endtask
    // One byte per command, then read back; res is {refused, done}, zero on timeout.
    task automatic zap(input logic [3:0] idx, input logic [7:0] val, output logic [1:0] res,
        output logic [7:0] back);
        logic ok;
        for (int k = 0; k < 1200 && prog_busy; k++) begin
            @(posedge clk_sys);
            #1;
        end
        prog_req = 1'b1;
        prog_idx = idx;
        prog_data = val;
        @(posedge clk_sys);
        #1 prog_req = 1'b0;
        prog_data = ~val; // Scrambled so stale data cannot help.
        res = {prog_refused, prog_done};
        for (int k = 0; k < 1100 && res == 2'b00; k++) begin
            @(posedge clk_sys);
            #1 res = {prog_refused, prog_done};
        end
        fetch(idx, back, ok);
    endtask
endmodule

// ---- dv/test_otps_param_store.sv ----
// Self-checking bench for the fuse parameter store.
module test_otps_param_store
    import otps_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0, rst_n = 1'b0, power_cycle = 1'b0, wake_up = 1'b0, set_req = 1'b0;
    logic comm_lost = 1'b0, err_overflow = 1'b0, goto_fallback_cmd = 1'b0, motor_stopped = 1'b0;
    logic supply_above_recover = 1'b0, ok;
    logic [2:0] strap_address_pins = 3'h5;
    otps_settings_t set_data = '0;
    otps_settings_t work;
    logic prog_req, prog_busy, prog_done, prog_refused, read_req, read_valid, fallback_go;
    logic fallback_hold, regulator_off, bridge_low_gnd, motion_detect_en, supply_recovered;
    logic [3:0] prog_idx, read_idx, coil_current_code;
    logic [7:0] prog_data, read_data, node_address, back;
    logic [15:0] fallback_pos;
    logic [4:0] step_divider;
    logic [1:0] res;
    int n_mismatch = 0, n_compared = 0;
    // Short debounce values keep the run brief.
    otps_param_store #(.DEB_SHORT_CYC(20), .DEB_LONG_CYC(60)) i_otps_param_store (
        .clk_sys, .rst_n, .power_cycle, .wake_up, .prog_req, .prog_idx, .prog_data,
        .prog_busy, .prog_done, .prog_refused, .read_req, .read_idx, .read_data,
        .read_valid, .set_req, .set_data, .work, .strap_address_pins, .node_address,
        .comm_lost, .err_overflow, .goto_fallback_cmd, .fallback_go, .fallback_hold,
        .fallback_pos, .motor_stopped, .coil_current_code, .regulator_off, .bridge_low_gnd,
        .step_divider, .motion_detect_en, .supply_above_recover, .supply_recovered);
    otps_master_model i_otps_master_model (.clk_sys, .prog_busy, .prog_done, .prog_refused,
        .read_data, .read_valid, .prog_req, .prog_idx, .prog_data, .read_req, .read_idx);
    // 100 MHz system clock.
    always #5 clk_sys = ~clk_sys;
    // Shared helpers.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic prog(input logic [3:0] idx, input logic [7:0] val, input logic [1:0] exp);
        i_otps_master_model.zap(idx, val, res, back);
        check("program outcome", res, exp);
        if (res == 2'b00) end_sim();
    endtask
    task automatic reload(input logic wk);
        power_cycle = !wk;
        wake_up = wk;
        tick(1);
        {power_cycle, wake_up} = 2'b00;
        tick(6); // Room for preload and merge.
    endtask
    // Delivery image, out-of-range readback and boot address.
    task automatic t_boot();
        i_otps_master_model.fetch(4'h7, back, ok);
        check("byte 7", back, 8'h02);
        tick(1);
        i_otps_master_model.fetch(4'hC, back, ok);
        check("byte 12", {ok, back}, 9'h100);
        check("boot address", node_address, 8'h05);
        $display("boot test done");
    endtask
    // Trial settings in the working copy before any fuse is touched.
    task automatic t_settings();
        for (int c = 0; c < 4; c++) begin
            set_data.step_res = c[1:0];
            set_data.dir = c[0];
            set_req = 1'b1;
            tick(1);
            set_req = 1'b0;
            tick(1);
            check("step divider", step_divider, 5'd2 << c);
            check("direction", work.dir, c[0]);
        end
        check("detect off", motion_detect_en, 1'b0);
        check("node kept", node_address, 8'h05);
        $display("settings test done");
    endtask
    // Byte programming, factory protection and power-cycle take-over.
    task automatic t_prog();
        prog(4'h3, 8'hF5, 2'b01);
        check("byte 3", back, 8'hF5);
        check("run early", work.run_code, 4'h0);
        prog(4'h0, 8'h01, 2'b10);
        prog(4'h0, 8'h80, 2'b01);
        prog(4'h0, 8'h80, 2'b01);
        check("byte 0", back, 8'h80);
        prog(4'h2, 8'h5A, 2'b01);
        prog(4'h5, 8'h80, 2'b01);
        reload(1'b0);
        check("run late", work.run_code, 4'hF);
        check("hold late", work.hold_code, 4'h5);
        check("fallback", work.fb_target, 11'h400);
        check("new address", node_address, 8'h55);
        check("detect on", motion_detect_en, 1'b1);
        $display("programming test done");
    endtask
    // Disabled automatic fallback, explicit move, alternate bank.
    task automatic t_fallback();
        comm_lost = 1'b1;
        tick(1);
        comm_lost = 1'b0;
        check("auto move held", {fallback_hold, fallback_go}, 2'b10);
        goto_fallback_cmd = 1'b1;
        tick(1);
        goto_fallback_cmd = 1'b0;
        check("explicit move", {fallback_go, fallback_pos}, 17'h1_8000);
        prog(4'h1, 8'h80, 2'b01);
        prog(4'h8, 8'h20, 2'b01);
        reload(1'b1);
        i_otps_master_model.fetch(4'h5, back, ok);
        check("alternate at 5", back, 8'h20);
        err_overflow = 1'b1;
        tick(1);
        err_overflow = 1'b0;
        check("alternate target", {fallback_go, fallback_pos}, 17'h1_2000);
        $display("fallback test done");
    endtask
    // Run, hold, and the zero-current sequence.
    task automatic t_current();
        check("run current", coil_current_code, 4'hF);
        motor_stopped = 1'b1;
        tick(1);
        check("hold current", coil_current_code, 4'h5);
        motor_stopped = 1'b0;
        set_data.run_code = 4'hF;
        set_data.hold_code = 4'hF;
        set_req = 1'b1;
        tick(1);
        set_req = 1'b0;
        tick(1);
        check("run again", coil_current_code, 4'hF);
        motor_stopped = 1'b1;
        tick(1);
        check("dip current", {regulator_off, coil_current_code}, 5'h00);
        for (int k = 0; k < 2100 && !regulator_off; k++) tick(1);
        check("bridge off", {regulator_off, bridge_low_gnd, coil_current_code}, 6'h30);
        $display("current test done");
    endtask
    // Supply recovery debounce with the short and the long setting.
    task automatic t_supply();
        for (int l = 0; l < 2; l++) begin
            set_data.deb_long = l[0];
            set_req = 1'b1;
            tick(1);
            set_req = 1'b0;
            supply_above_recover = 1'b1;
            tick(l ? 63 : 23); // Three sync stages plus a debounce of 20 or 60 cycles.
            check("early recovery", supply_recovered, 1'b0);
            tick(1);
            check("recovered", supply_recovered, 1'b1);
            supply_above_recover = 1'b0;
            tick(5);
            check("recovery dropped", supply_recovered, 1'b0);
        end
        $display("supply test done");
    endtask
    // User lock closes the whole store.
    task automatic t_lock();
        prog(4'h7, 8'h01, 2'b01);
        check("byte 7 locked", back, 8'h03);
        prog(4'h2, 8'h80, 2'b10);
        prog(4'hA, 8'h01, 2'b10);
        $display("lock test done");
    endtask
    // Main sequence.
    initial begin
        tick(3);
        rst_n = 1'b1;
        tick(4);
        t_boot();
        t_settings();
        t_prog();
        t_fallback();
        t_current();
        t_supply();
        t_lock();
        end_sim();
    end
endmodule
